// >>> rtl/serial_status_data.v
// Purpose: asynchronous serial transceiver with status flags and data registers
// Assumes: Avalon-MM slave, one wait state per access; rxd synchronous to i_clock
// Notes: baud divisor counts clocks per oversample tick, sixteen ticks per bit
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_data_map.vh"
module serial_status_data #(
    parameter BAUD_W = 13
) (
    input wire i_clock,
    input wire i_rstn,
    input wire [2:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    input wire [3:0] i_byteenable,
    output reg [31:0] o_readdata,
    output wire o_waitrequest,
    input wire i_rxd,
    output reg o_txd,
    output wire o_txd_oe,
    output wire o_irq
);
    // ------------------------------------------------------------
    // registers and bus handshake
    // ------------------------------------------------------------
    reg [BAUD_W-1:0] baud_ff;
    reg [4:0] ctrl1_ff;
    reg [7:0] ctrl2_ff;
    reg ack_ff;
    reg tx_empty_ff, tx_done_ff, rx_full_ff, idle_ff, over_ff, noise_ff, fe_ff, pe_ff;
    reg busy_ff;
    reg [7:0] seen_ff;
    reg tx_armed_ff;
    reg tx_nine_ff, rx_nine_ff;
    reg [7:0] rx_hold_ff, tx_hold_ff;
    reg tx_pending_ff;
    wire [7:0] stat1 = {tx_empty_ff, tx_done_ff, rx_full_ff, idle_ff,
                        over_ff, noise_ff, fe_ff, pe_ff};
    wire acc = (i_read | i_write) & !ack_ff;
    wire do_rd = i_read & ack_ff;
    wire do_wr = i_write & ack_ff & i_byteenable[0];
    wire rd_stat = do_rd && (i_address == `REG_STAT_ONE);
    wire rd_data = do_rd && (i_address == `REG_DATA_LOW);
    wire wr_data = do_wr && (i_address == `REG_DATA_LOW);
    wire nine = ctrl1_ff[`C1_NINE];
    wire tx_on = ctrl2_ff[`C2_TX_ON];
    wire rx_on = ctrl2_ff[`C2_RX_ON];
    wire rx_sleep = ctrl2_ff[`C2_SLEEP];
    wire send_break = ctrl2_ff[`C2_BREAK];
    wire par_en = ctrl1_ff[`C1_PAR_EN];
    wire parity_odd_sel = ctrl1_ff[`C1_PAR_ODD];
    assign o_waitrequest = (i_read | i_write) & !ack_ff;
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn)
            ack_ff <= 1'b0;
        else
            ack_ff <= acc;
    end

    // ------------------------------------------------------------
    // oversample tick divider
    // ------------------------------------------------------------
    reg [BAUD_W-1:0] div_ff;
    reg tick;
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            div_ff <= {BAUD_W{1'b0}};
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (!(tx_on | rx_on) || baud_ff == {BAUD_W{1'b0}}) begin
                div_ff <= {BAUD_W{1'b0}};
            end else if (div_ff >= baud_ff - 1'b1) begin
                div_ff <= {BAUD_W{1'b0}};
                tick <= 1'b1;
            end else begin
                div_ff <= div_ff + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    localparam TX_IDLE = 2'h0;
    localparam TX_DATA = 2'h1;
    localparam TX_PRE = 2'h2;
    localparam TX_BRK = 2'h3;
    reg [1:0] tx_st_ff;
    reg [3:0] tx_ph_ff;
    reg [3:0] tx_bit_ff;
    reg [10:0] tx_sh_ff;
    reg tx_on_d_ff;
    reg pre_q_ff;
    wire [3:0] frame_len = nine ? `BITS_9 : `BITS_8;
    wire tx_par = (nine ? ^tx_hold_ff : ^tx_hold_ff[6:0]) ^ parity_odd_sel;
    // with parity the last data position carries the parity bit
    wire b7 = (par_en & !nine) ? tx_par : tx_hold_ff[7];
    wire b8 = par_en ? tx_par : tx_nine_ff;
    wire bit_end = tick && (tx_ph_ff == `OVS_LAST);
    wire frame_end = bit_end && (tx_bit_ff == frame_len - 4'h1);
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_st_ff <= TX_IDLE;
            tx_ph_ff <= 4'h0;
            tx_bit_ff <= 4'h0;
            tx_sh_ff <= 11'h7FF;
            o_txd <= 1'b1;
            tx_on_d_ff <= 1'b0;
            pre_q_ff <= 1'b0;
            tx_pending_ff <= 1'b0;
        end else begin
            tx_on_d_ff <= tx_on;
            if (tx_on & !tx_on_d_ff)
                pre_q_ff <= 1'b1;
            if (wr_data & tx_armed_ff)
                tx_pending_ff <= 1'b1;
            if (!tx_on) begin
                tx_st_ff <= TX_IDLE;
                o_txd <= 1'b1;
            end else if (tx_st_ff == TX_IDLE) begin
                tx_ph_ff <= 4'h0;
                tx_bit_ff <= 4'h0;
                if (send_break) begin
                    tx_st_ff <= TX_BRK;
                    o_txd <= 1'b0;
                end else if (pre_q_ff) begin
                    pre_q_ff <= 1'b0;
                    tx_st_ff <= TX_PRE;
                    o_txd <= 1'b1;
                end else if (tx_pending_ff) begin
                    tx_pending_ff <= 1'b0;
                    tx_sh_ff <= {1'b1, b8, b7, tx_hold_ff[6:0], 1'b0};
                    tx_st_ff <= TX_DATA;
                    o_txd <= 1'b0;
                end else begin
                    o_txd <= 1'b1;
                end
            end else if (tick) begin
                tx_ph_ff <= tx_ph_ff + 4'h1;
                if (bit_end) begin
                    tx_bit_ff <= tx_bit_ff + 4'h1;
                    if (tx_st_ff == TX_DATA)
                        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                end
                if (frame_end && tx_st_ff == TX_BRK && send_break) begin
                    // held break restarts the zero run with no high gap
                    tx_bit_ff <= 4'h0;
                end else if (frame_end) begin
                    tx_st_ff <= TX_IDLE;
                    o_txd <= 1'b1;
                end else if (bit_end) begin
                    case (tx_st_ff)
                        TX_DATA: o_txd <= (nine || tx_bit_ff != 4'h8) ? tx_sh_ff[1] : 1'b1;
                        TX_BRK: o_txd <= 1'b0;
                        default: o_txd <= 1'b1;
                    endcase
                end
            end
        end
    end
    assign o_txd_oe = tx_on;

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    reg [3:0] rx_ph_ff;
    reg [3:0] rx_bit_ff;
    reg [8:0] rx_sh_ff;
    reg rx_noise_ff;
    reg [3:0] ones_ff;
    reg idle_ok_ff;
    reg in_frame_ff;
    wire v_bit, v_noise;
    line_voter u_voter (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_tick(tick),
        .i_phase(rx_ph_ff),
        .i_rxd(i_rxd),
        .o_bit(v_bit),
        .o_noise(v_noise)
    );
    // voter outputs settle one clock after the vote tick
    reg vote_ff;
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn)
            vote_ff <= 1'b0;
        else
            vote_ff <= tick && (rx_ph_ff == `OVS_S3) && in_frame_ff;
    end
    wire rx_done = vote_ff && (rx_bit_ff == frame_len - 4'h1);
    wire [7:0] rx_byte = nine ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
    wire rx_par_bit = nine ? rx_sh_ff[8] : rx_sh_ff[8];
    wire [7:0] par_src = nine ? rx_sh_ff[7:0] : {1'b0, rx_sh_ff[7:1]};
    wire par_bad = par_en && (((^par_src) ^ parity_odd_sel) != rx_par_bit);
    wire line_one = tick && (rx_ph_ff == `OVS_LAST) && !in_frame_ff && i_rxd;
    wire wake_hit = rx_done && ctrl1_ff[`C1_WAKE_ADDR] && rx_sh_ff[8];
    wire idle_hit = line_one && (ones_ff == frame_len - 4'h1);
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_ph_ff <= 4'h0;
            rx_bit_ff <= 4'h0;
            rx_sh_ff <= 9'h000;
            rx_noise_ff <= 1'b0;
            ones_ff <= 4'h0;
            in_frame_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else if (!rx_on) begin
            in_frame_ff <= 1'b0;
            busy_ff <= 1'b0;
            rx_ph_ff <= 4'h0;
            ones_ff <= 4'h0;
        end else begin
            if (tick)
                rx_ph_ff <= rx_ph_ff + 4'h1;
            if (!in_frame_ff && tick) begin
                if (!i_rxd && !busy_ff) begin
                    busy_ff <= 1'b1;
                    rx_ph_ff <= 4'h1;
                    ones_ff <= 4'h0;
                end else if (busy_ff && rx_ph_ff == `OVS_S1) begin
                    in_frame_ff <= 1'b1;
                    rx_bit_ff <= 4'h0;
                    rx_noise_ff <= 1'b0;
                end else if (line_one) begin
                    if (ones_ff != `BITS_9)
                        ones_ff <= ones_ff + 4'h1;
                    if (idle_hit)
                        busy_ff <= 1'b0;
                end
            end
            if (vote_ff) begin
                rx_noise_ff <= rx_noise_ff | v_noise;
                if (rx_bit_ff == 4'h0 && v_bit) begin
                    in_frame_ff <= 1'b0;
                    busy_ff <= 1'b0;
                end else begin
                    rx_bit_ff <= rx_bit_ff + 4'h1;
                    if (rx_bit_ff != 4'h0 && rx_bit_ff != frame_len - 4'h1)
                        rx_sh_ff <= {v_bit, rx_sh_ff[8:1]};
                end
                if (rx_done) begin
                    in_frame_ff <= 1'b0;
                    busy_ff <= 1'b0;
                    ones_ff <= v_bit ? 4'h1 : 4'h0;
                end
            end
        end
    end
    // idle search is re-armed by a new received character
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn)
            idle_ok_ff <= 1'b0;
        else if (idle_ff & !(rd_data & seen_ff[`S1_IDLE]))
            idle_ok_ff <= 1'b0;
        else if (rx_done & !rx_full_ff & !over_ff)
            idle_ok_ff <= 1'b1;
    end

    // ------------------------------------------------------------
    // status flags and clearing sequences
    // ------------------------------------------------------------
    wire clr_rx = rd_data;
    wire clr_tx = wr_data & tx_armed_ff;
    wire load_rx = rx_done & !rx_full_ff & !over_ff & !(rx_sleep & !wake_hit);
    wire tx_loading = tx_on && tx_st_ff == TX_IDLE && !send_break && !pre_q_ff && tx_pending_ff;
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_empty_ff <= 1'b1;
            tx_done_ff <= 1'b1;
            rx_full_ff <= 1'b0;
            idle_ff <= 1'b0;
            over_ff <= 1'b0;
            noise_ff <= 1'b0;
            fe_ff <= 1'b0;
            pe_ff <= 1'b0;
            seen_ff <= 8'h00;
            tx_armed_ff <= 1'b0;
            rx_hold_ff <= 8'h00;
            rx_nine_ff <= 1'b0;
        end else begin
            if (rd_stat) begin
                seen_ff <= o_readdata[7:0];
                tx_armed_ff <= o_readdata[`S1_TX_EMPTY] | o_readdata[`S1_TX_DONE];
            end else if (clr_rx | wr_data) begin
                tx_armed_ff <= wr_data ? 1'b0 : tx_armed_ff;
            end
            if (clr_tx) begin
                tx_empty_ff <= tx_empty_ff & !seen_ff[`S1_TX_EMPTY];
            end
            if (tx_loading)
                tx_empty_ff <= 1'b1;
            tx_done_ff <= (tx_st_ff == TX_IDLE && !tx_pending_ff && !pre_q_ff) &&
                          !(clr_tx && seen_ff[`S1_TX_DONE]);
            if (clr_rx) begin
                rx_full_ff <= rx_full_ff & !seen_ff[`S1_RX_FULL];
                idle_ff <= idle_ff & !seen_ff[`S1_IDLE];
                over_ff <= over_ff & !seen_ff[`S1_OVERRUN];
                noise_ff <= noise_ff & !seen_ff[`S1_NOISE];
                fe_ff <= fe_ff & !seen_ff[`S1_FRAMING];
                pe_ff <= pe_ff & !seen_ff[`S1_PARITY];
                seen_ff <= 8'h00;
            end
            if (load_rx) begin
                rx_full_ff <= 1'b1;
                rx_hold_ff <= rx_byte;
                rx_nine_ff <= nine & rx_sh_ff[8];
                noise_ff <= rx_noise_ff | v_noise;
                fe_ff <= !v_bit;
                pe_ff <= par_bad;
            end
            if (rx_done & (rx_full_ff | over_ff) & !rx_sleep)
                over_ff <= 1'b1;
            if (idle_hit & idle_ok_ff & !rx_sleep)
                idle_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    wire wake_idle = idle_hit & !ctrl1_ff[`C1_WAKE_ADDR];
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            baud_ff <= `BAUD_RESET;
            ctrl1_ff <= 5'h00;
            ctrl2_ff <= 8'h00;
            tx_nine_ff <= 1'b0;
            tx_hold_ff <= 8'h00;
        end else begin
            if (do_wr) begin
                case (i_address)
                    `REG_BAUD: baud_ff <= i_writedata[BAUD_W-1:0];
                    `REG_CTRL_ONE: ctrl1_ff <= i_writedata[4:0];
                    `REG_CTRL_TWO: ctrl2_ff <= i_writedata[7:0];
                    `REG_DATA_HIGH: tx_nine_ff <= i_writedata[`DH_TX_NINE];
                    `REG_DATA_LOW: if (tx_armed_ff) tx_hold_ff <= i_writedata[7:0];
                    default: ;
                endcase
            end
            if (rx_sleep & (wake_idle | wake_hit))
                ctrl2_ff[`C2_SLEEP] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data and interrupt
    // ------------------------------------------------------------
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_readdata <= 32'h00000000;
        end else if (acc & i_read) begin
            case (i_address)
                `REG_BAUD: o_readdata <= {{(32-BAUD_W){1'b0}}, baud_ff};
                `REG_CTRL_ONE: o_readdata <= {27'h0000000, ctrl1_ff};
                `REG_CTRL_TWO: o_readdata <= {24'h000000, ctrl2_ff};
                `REG_STAT_ONE: o_readdata <= {24'h000000, stat1};
                `REG_STAT_TWO: o_readdata <= {31'h00000000, busy_ff};
                `REG_DATA_HIGH: o_readdata <= {24'h000000, rx_nine_ff, tx_nine_ff, 6'h00};
                `REG_DATA_LOW: o_readdata <= {24'h000000, rx_hold_ff};
                default: o_readdata <= 32'h00000000;
            endcase
        end
    end
    assign o_irq = (ctrl2_ff[`C2_TX_IRQ] & tx_empty_ff) |
                   (ctrl2_ff[`C2_TXDONE_IRQ] & tx_done_ff) |
                   (ctrl2_ff[`C2_RX_IRQ] & !rx_sleep & (rx_full_ff | over_ff)) |
                   (ctrl2_ff[`C2_IDLE_IRQ] & idle_ff);
endmodule // serial_status_data
`default_nettype wire

// >>> rtl/serial_status_data_map.vh
// Purpose: register offsets, field positions and constants of the serial transceiver block
// Assumes: Avalon-MM slave with 32-bit data, one register per aligned word
// Notes: included by the transceiver top and its line sampler
//
// Notes on behaviour
// - idle_irq_en gates the idle flag onto the serial interrupt request.
// - tx_on claims the transmit pin and queues an idle preamble; rx_on enables receiver.
// - rx_sleep blocks receive interrupts; hardware clears it on wakeup condition.
// - send_break held sends continuous zeros, each break at least 10 or 11 zeros.
// - clearing send_break finishes the current all-zero frame before idling.
// - a short send_break pulse gives exactly one break, then idle or data.
// - receive flags clear by status read then data low read, only those seen set.
// - tx_buf_empty and tx_done clear by status read then data low write.
// - reset sets tx_buf_empty; set on shift load; unarmed write sends nothing.
// - tx_done is one only when no frame, preamble or break is in progress.
// - rx_buf_full sets when a received character lands in the holding register.
// - idle flag sets after 10 or 11 ones, never while rx_sleep is one.
// - after clearing, idle flag waits for rx_buf_full before setting again.
// - a character completing while rx_buf_full is set is dropped, and sets overrun unless rx_sleep is one.
// - noise flag sets with rx_buf_full on sample disagreement, never on overrun.
// - framing_err sets on a zero in the stop position; clears by the read sequence.
// - parity_err sets on parity mismatch when parity enabled, else stays zero.
// - rx_busy_flag sets at first_sample_tick of start search; clears on idle, false start or end of character.
// - rx_bit_nine is read-only in the upper data register; writes ignored.
// - tx_bit_nine is sent with every nine-bit frame without parity until rewritten.
// - data low read returns receive holding; armed write loads transmit holding.
// - format bit selects eight or nine data bits between start and stop.
// - parity_odd_sel zero means even parity, one means odd, both directions.
// - rx_irq_en requests the interrupt while rx_buf_full or overrun is set.
`ifndef SERIAL_STATUS_DATA_MAP_VH
`define SERIAL_STATUS_DATA_MAP_VH

// word addresses of the registers
`define REG_BAUD 3'h0
`define REG_CTRL_ONE 3'h1
`define REG_CTRL_TWO 3'h2
`define REG_STAT_ONE 3'h3
`define REG_STAT_TWO 3'h4
`define REG_DATA_HIGH 3'h5
`define REG_DATA_LOW 3'h6

// control one fields
`define C1_NINE 4
`define C1_WAKE_ADDR 3
`define C1_IDLE_LONG 2
`define C1_PAR_EN 1
`define C1_PAR_ODD 0

// control two fields
`define C2_TX_IRQ 7
`define C2_TXDONE_IRQ 6
`define C2_RX_IRQ 5
`define C2_IDLE_IRQ 4
`define C2_TX_ON 3
`define C2_RX_ON 2
`define C2_SLEEP 1
`define C2_BREAK 0

// status one fields
`define S1_TX_EMPTY 7
`define S1_TX_DONE 6
`define S1_RX_FULL 5
`define S1_IDLE 4
`define S1_OVERRUN 3
`define S1_NOISE 2
`define S1_FRAMING 1
`define S1_PARITY 0

// data high fields
`define DH_RX_NINE 7
`define DH_TX_NINE 6

// oversampling: ticks per bit and vote sample points
`define OVS_LAST 4'hF
`define OVS_S1 4'h7
`define OVS_S2 4'h8
`define OVS_S3 4'h9
`define BITS_8 4'hA
`define BITS_9 4'hB
`define BAUD_RESET 13'h0001

`endif

// >>> rtl/line_voter.v
// Purpose: three-sample majority vote of the receive line within one bit time
// Assumes: i_rxd synchronous to i_clock; i_tick is the oversample enable
// Notes: o_noise flags any disagreement among the three samples
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_data_map.vh"
module line_voter (
    input wire i_clock,
    input wire i_rstn,
    input wire i_tick,
    input wire [3:0] i_phase,
    input wire i_rxd,
    output reg o_bit,
    output reg o_noise
);
    reg s1_ff;
    reg s2_ff;
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            o_bit <= 1'b1;
            o_noise <= 1'b0;
        end else if (i_tick) begin
            if (i_phase == `OVS_S1)
                s1_ff <= i_rxd;
            if (i_phase == `OVS_S2)
                s2_ff <= i_rxd;
            if (i_phase == `OVS_S3) begin
                o_bit <= (s1_ff & s2_ff) | (s1_ff & i_rxd) | (s2_ff & i_rxd);
                o_noise <= !((s1_ff == s2_ff) && (s2_ff == i_rxd));
            end
        end
    end
endmodule // line_voter
`default_nettype wire

// >>> test/serial_status_data_props.sv
// Purpose: port-level checker for the serial status and data block
// Assumes: baud register left at its reset value, sixteen clocks per bit
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module serial_status_data_props #(
    parameter BAUD_W = 13
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [2:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic i_rxd,
    input wire logic o_txd,
    input wire logic o_txd_oe,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    wire logic take = (i_read || i_write) && !o_waitrequest;
    wire logic ctl_wr = take && i_write && i_address == 3'h2 && i_byteenable[0];
    wire logic st_rd = take && i_read && i_address == 3'h3;
    logic [7:0] ctl_ff;
    logic [9:0] low_ff;
    // ----
    // shadow of control two and length of the current low run on the line
    // ----
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ctl_ff <= 8'h00;
            low_ff <= 10'h000;
        end else begin
            if (ctl_wr) ctl_ff <= i_writedata[7:0];
            low_ff <= o_txd ? 10'h000 : low_ff + 10'h001;
        end
    end
    sequence s_req_start;
        $rose(i_read || i_write);
    endsequence
    sequence s_one_wait;
        o_waitrequest ##1 !o_waitrequest;
    endsequence
    a_one_wait: assert property (s_req_start |-> s_one_wait)
        else $error("bus access without exactly one wait state");
    a_oe_follows: assert property (ctl_wr |=> o_txd_oe == $past(i_writedata[3]))
        else $error("pin enable does not follow the transmitter enable");
    a_oe_steady: assert property ($changed(o_txd_oe) |-> $past(ctl_wr))
        else $error("pin enable moved without a control write");
    a_unmapped_zero: assert property (take && i_read && i_address == 3'h7 |-> o_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_stat2_upper: assert property (take && i_read && i_address == 3'h4 |-> o_readdata[31:1] == 31'h0)
        else $error("status two unused bits set");
    a_irq_quiet: assert property (ctl_ff[7:4] == 4'h0 |-> !o_irq)
        else $error("interrupt with all enables off");
    a_rx_irq: assert property (st_rd && ctl_ff[5] && !ctl_ff[1] && o_readdata[5] |-> o_irq)
        else $error("receive full without interrupt");
    a_idle_irq: assert property (st_rd && ctl_ff[4] && o_readdata[4] |-> o_irq)
        else $error("idle flag without interrupt");
    a_bit_whole: assert property ($rose(o_txd) |-> low_ff >= 10'h010)
        else $error("low level shorter than one bit");
    a_break_min: assert property ($rose(o_txd) && low_ff > 10'h090 |-> low_ff >= 10'h0A0)
        else $error("break shorter than ten bits");
endmodule // serial_status_data_props
bind serial_status_data serial_status_data_props #(.BAUD_W(BAUD_W)) props_u (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_rxd(i_rxd),
    .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_irq(o_irq));
`default_nettype wire

// >>> test/line_peer.sv
// Purpose: remote serial end: sends frames on the receive line, decodes the transmit line
// Assumes: sixteen clocks per bit, eight data bits, lsb first
// Notes: also records the longest low run seen on the transmit line
`timescale 1ns/10ps
`default_nettype none
module line_peer (
    input wire logic i_clock,
    input wire logic i_txd,
    output logic o_rxd
);
    logic [7:0] got = 8'h00;
    int n_frames = 0;
    int low_run = 0;
    int max_low = 0;
    initial o_rxd = 1'b1;
    task automatic send(input logic [7:0] data, input logic stop);
        logic [9:0] frame;
        frame = {stop, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd <= frame[i];
            repeat (16) @(posedge i_clock);
        end
        o_rxd <= 1'b1;
        repeat (32) @(posedge i_clock);
    endtask
    always @(posedge i_clock) begin
        low_run <= i_txd ? 0 : low_run + 1;
        if (!i_txd && low_run + 1 > max_low) max_low <= low_run + 1;
    end
    // decode at mid bit after each falling edge
    initial begin
        forever begin
            @(negedge i_txd);
            repeat (8) @(posedge i_clock);
            for (int i = 0; i < 8; i++) begin
                repeat (16) @(posedge i_clock);
                got[i] = i_txd;
            end
            repeat (16) @(posedge i_clock);
            n_frames++;
        end
    end
endmodule // line_peer
`default_nettype wire

// >>> test/serial_status_data_tb.sv
// Purpose: self-checking bench for the serial status and data block
// Assumes: baud register left at reset, sixteen clocks per bit
// Notes: register rows first, then transmit, receive and break cases
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module serial_status_data_tb;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic [2:0] i_address = 3'h0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    wire logic [31:0] o_readdata;
    wire logic o_waitrequest, o_txd, o_txd_oe, o_irq, rxd;
    int n_mismatch = 0;
    int comparisons = 0;
    int n0;
    logic [31:0] rd;
    // {write, address, write data, expected read}
    logic [19:0] rows [11] = '{20'h300C0, 20'hBFF00, 20'h300C0, 20'h91F00, 20'h1001F,
        20'h90000, 20'h70000, 20'hFFF00, 20'hDFF00, 20'h50040, 20'h40000};
    serial_status_data #(.BAUD_W(13)) dut_u (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(4'hF), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_rxd(rxd), .o_txd(o_txd),
        .o_txd_oe(o_txd_oe), .o_irq(o_irq));
    line_peer peer_u (.i_clock(i_clock), .i_txd(o_txd), .o_rxd(rxd));
    always #4 i_clock = ~i_clock;
    // ----
    // bus master and helpers
    // ----
    task automatic bus(input logic [2:0] a, input logic wr, input logic [7:0] wd,
        output logic [31:0] d);
        i_address <= a;
        i_writedata <= {24'h000000, wd};
        i_write <= wr;
        i_read <= !wr;
        do @(posedge i_clock); while (o_waitrequest !== 1'b0);
        d = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic wait_flag(input int b, input logic v);
        int n;
        n = 0;
        do begin bus(3'h3, 1'b0, 8'h00, rd); n++; end while (rd[b] !== v && n < 400);
        `CHK("status wait", v, rd[b])
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_clock);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(posedge i_clock);
        `CHK("irq idle", 1'b0, o_irq)
        foreach (rows[k]) begin
            bus(rows[k][18:16], rows[k][19], rows[k][15:8], rd);
            if (!rows[k][19]) `CHK("row read", rows[k][7:0], rd[7:0])
        end
        bus(3'h2, 1'b1, 8'h08, rd);
        `CHK("pin enable", 1'b1, o_txd_oe)
        wait_flag(6, 1'b0);
        wait_flag(6, 1'b1);
        n0 = peer_u.n_frames;
        bus(3'h6, 1'b1, 8'hA5, rd);
        bus(3'h3, 1'b0, 8'h00, rd);
        `CHK("done busy", 1'b0, rd[6])
        bus(3'h6, 1'b1, 8'h5A, rd);
        bus(3'h6, 1'b1, 8'h0F, rd);
        wait_flag(6, 1'b1);
        `CHK("frames sent", n0 + 2, peer_u.n_frames)
        `CHK("last frame", 8'h5A, peer_u.got)
        bus(3'h2, 1'b1, 8'h3C, rd);
        peer_u.send(8'h3C, 1'b1);
        wait_flag(5, 1'b1);
        `CHK("rx irq", 1'b1, o_irq)
        bus(3'h6, 1'b0, 8'h00, rd);
        `CHK("rx data", 8'h3C, rd[7:0])
        bus(3'h3, 1'b0, 8'h00, rd);
        `CHK("rx cleared", 2'b00, {rd[5], rd[3]})
        peer_u.send(8'h11, 1'b1);
        peer_u.send(8'h22, 1'b1);
        bus(3'h3, 1'b0, 8'h00, rd);
        `CHK("overrun", 3'b110, {rd[5], rd[3], rd[2]})
        bus(3'h6, 1'b0, 8'h00, rd);
        `CHK("kept first", 8'h11, rd[7:0])
        bus(3'h3, 1'b0, 8'h00, rd);
        `CHK("overrun cleared", 2'b00, {rd[5], rd[3]})
        peer_u.send(8'h55, 1'b0);
        wait_flag(5, 1'b1);
        wait_flag(4, 1'b1);
        `CHK("framing", 2'b10, rd[1:0])
        bus(3'h6, 1'b0, 8'h00, rd);
        bus(3'h3, 1'b0, 8'h00, rd);
        `CHK("framing cleared", 1'b0, rd[1])
        peer_u.max_low = 0;
        bus(3'h2, 1'b1, 8'h09, rd);
        repeat (20) @(posedge i_clock);
        bus(3'h2, 1'b1, 8'h08, rd);
        wait_flag(6, 1'b1);
        `CHK("break once", 1'b1, peer_u.max_low >= 160 && peer_u.max_low < 176)
        summarize();
    end
endmodule // serial_status_data_tb
`default_nettype wire
